//--- bvs_pkg.sv
// Constants and types for the boot vector selector.
// Assumes a byte-wide code flash read port with a fixed read latency of one cycle.
// Summary of operation
// - The flash byte just below the lock byte is read as the loader signature byte.
// - A signature of A5 hex means a resident loader is present.
// - Any other signature value, erased included, means no loader.
// - With a loader present, every reset starts execution at the loader vector.
// - With no loader, every reset starts execution at address zero.
// - The loader lives in the last flash page, which stays erasable.
// - The running loader either stays in loader mode or leaves it on an exit, which keeps the start vector at the loader vector.
// - The loader talks on fixed pins: serial TX P0.4, RX P0.5; two-wire data P0.2, clock P0.3.
package bvs_pkg;
    localparam logic [15:0] BVS_LOCK_ADDR    = 16'hFBFF;
    localparam logic [15:0] BVS_SIG_ADDR     = BVS_LOCK_ADDR - 16'h0001;
    localparam logic [15:0] BVS_PAGE_BASE    = 16'hFA00;
    localparam logic [15:0] BVS_LOADER_VEC   = BVS_PAGE_BASE;
    localparam logic [15:0] BVS_RESET_VEC    = 16'h0000;
    localparam logic [7:0]  BVS_SIG_PRESENT  = 8'hA5;
    localparam logic [2:0]  BVS_PIN_UART_TX  = 3'h4;
    localparam logic [2:0]  BVS_PIN_UART_RX  = 3'h5;
    localparam logic [2:0]  BVS_PIN_TW_DATA  = 3'h2;
    localparam logic [2:0]  BVS_PIN_TW_CLK   = 3'h3;

    typedef enum logic [1:0] {
        BVS_ST_ADDR = 2'b00,
        BVS_ST_WAIT = 2'b01,
        BVS_ST_RUN  = 2'b10
    } bvs_state_t;
endpackage

//--- bvs_boot_vector_select.sv
// Boot vector selector: reads the loader signature after reset and steers the first fetch.
// Assumes flash returns FLASH_RDATA one cycle after FLASH_RD with FLASH_ADDR.
module bvs_boot_vector_select
    import bvs_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Code flash read port
    output logic [15:0]      FLASH_ADDR,
    output logic             FLASH_RD,
    input  wire logic [7:0]  FLASH_RDATA,
    // Core fetch control
    output logic             CORE_RUN,
    output logic [15:0]      START_VEC,
    output logic             LOADER_MODE,
    input  wire logic        LOADER_EXIT,
    // Loader pin routing on port 0
    input  wire logic        LOADER_TWO_WIRE,
    output logic [7:0]       P0_ROUTE_MASK
);

    // Sequencing state
    bvs_state_t  state_ff;
    bvs_state_t  nxt_state;

    // Flash read port registers
    logic [15:0] addr_ff;
    logic [15:0] nxt_addr;
    logic        rd_ff;
    logic        nxt_rd;

    // Boot decision registers
    logic        run_ff;
    logic        nxt_run;
    logic [15:0] vec_ff;
    logic [15:0] nxt_vec;
    logic        ldr_ff;
    logic        nxt_ldr;
    logic [7:0]  mask_ff;
    logic [7:0]  nxt_mask;

    // Presence test; an erased byte or any stray value means no loader
    function automatic logic sig_present(
        input logic [7:0] sig
    );
        sig_present = (sig == BVS_SIG_PRESENT);
    endfunction

    // A port-0 bit belongs to the loader when it is one of the variant's two pins
    function automatic logic pin_owned(
        input logic [2:0] bit_idx,
        input logic       two_wire
    );
        if (two_wire) begin
            pin_owned = (bit_idx == BVS_PIN_TW_DATA) || (bit_idx == BVS_PIN_TW_CLK);
        end else begin
            pin_owned = (bit_idx == BVS_PIN_UART_TX) || (bit_idx == BVS_PIN_UART_RX);
        end
    endfunction

    // First fetch address for a given presence decision
    function automatic logic [15:0] start_addr(
        input logic present
    );
        if (present) begin
            start_addr = BVS_LOADER_VEC;
        end else begin
            start_addr = BVS_RESET_VEC;
        end
    endfunction

    // Decoded conditions
    wire logic       sampled;
    wire logic       in_run;
    wire logic       found;
    wire logic       exit_req;
    wire logic [7:0] ldr_pins;

    assign sampled  = (state_ff == BVS_ST_WAIT);
    assign in_run   = (state_ff == BVS_ST_RUN);
    assign found    = sig_present(FLASH_RDATA);

    // An exit in the sample cycle is ignored: the fresh decision must win
    assign exit_req = ldr_ff && LOADER_EXIT && in_run;

    // Ownership is decoded per line so each port-0 bit has its own select
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            assign ldr_pins[gi] = pin_owned(3'(gi), LOADER_TWO_WIRE);
        end
    endgenerate

    // Sequencer: one cycle to present the address, one to take the byte
    always_comb begin
        case (state_ff)
            BVS_ST_ADDR: begin
                nxt_state = BVS_ST_WAIT;
            end
            BVS_ST_WAIT: begin
                nxt_state = BVS_ST_RUN;
            end
            BVS_ST_RUN: begin
                nxt_state = BVS_ST_RUN;
            end
            default: begin
                nxt_state = BVS_ST_ADDR;
            end
        endcase
    end

    // The signature is read once per reset; the address never moves
    assign nxt_addr = BVS_SIG_ADDR;
    assign nxt_rd   = 1'b0;

    // Core is held off until the vector is settled, so no fetch precedes the sample
    assign nxt_run  = run_ff || sampled;
    assign nxt_vec  = sampled ? start_addr(found) : vec_ff;

    // Loader mode is set only by the sample and left only by an exit request
    always_comb begin
        if (sampled) begin
            nxt_ldr = found;
        end else if (exit_req) begin
            nxt_ldr = 1'b0;
        end else begin
            nxt_ldr = ldr_ff;
        end
    end

    // Pins are claimed only while the loader owns them
    always_comb begin
        if (sampled) begin
            nxt_mask = found ? ldr_pins : 8'h00;
        end else if (exit_req) begin
            nxt_mask = 8'h00;
        end else begin
            nxt_mask = mask_ff;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= BVS_ST_ADDR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Address is a flop so the port comes straight from a register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_ff <= BVS_SIG_ADDR;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // Read strobe stands through reset so the byte is ready at the first edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_ff <= 1'b1;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            vec_ff <= BVS_RESET_VEC;
        end else begin
            vec_ff <= nxt_vec;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ldr_ff <= 1'b0;
        end else begin
            ldr_ff <= nxt_ldr;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_ff <= 8'h00;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // Outputs
    assign FLASH_ADDR    = addr_ff;
    assign FLASH_RD      = rd_ff;
    assign CORE_RUN      = run_ff;
    assign START_VEC     = vec_ff;
    assign LOADER_MODE   = ldr_ff;
    assign P0_ROUTE_MASK = mask_ff;

endmodule

//--- bvs_checker.sv
// Checker bound below to the selector ports; one clock, reset low.
module bvs_checker import bvs_pkg::*; (
    input logic CLK, RST_N, CORE_RUN, LOADER_MODE, LOADER_EXIT, LOADER_TWO_WIRE,
    input logic [15:0] FLASH_ADDR, START_VEC,
    input logic [7:0] FLASH_RDATA, P0_ROUTE_MASK);
    timeunit 1ns / 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_dark; !CORE_RUN [*2]; endsequence
    sig_addr_a: assert property (FLASH_ADDR == BVS_SIG_ADDR) else $error("addr");
    run_time_a: assert property ($rose(RST_N) |-> s_dark ##1 CORE_RUN) else $error("run");
    loader_vec_a: assert property ($rose(CORE_RUN) && $past(FLASH_RDATA) == 8'hA5
        |-> LOADER_MODE && START_VEC == BVS_LOADER_VEC) else $error("loader");
    plain_vec_a: assert property ($rose(CORE_RUN) && $past(FLASH_RDATA) != 8'hA5
        |-> !LOADER_MODE && START_VEC == 16'h0000) else $error("plain");
    vec_hold_a: assert property (CORE_RUN |=> $stable(START_VEC)) else $error("hold");
    loader_exit_a: assert property (LOADER_EXIT && LOADER_MODE |=> !{LOADER_MODE, P0_ROUTE_MASK})
        else $error("exit");
    pin_mask_a: assert property (LOADER_MODE |-> P0_ROUTE_MASK ==
        (LOADER_TWO_WIRE ? 8'h0C : 8'h30)) else $error("pins");
    page_base_a: assert property (LOADER_MODE |-> START_VEC == BVS_PAGE_BASE) else $error("page");
endmodule
bind bvs_boot_vector_select bvs_checker u_bvs_checker (.*);

//--- bvs_flash.sv
// Flash stand-in: signature byte a cycle after a read; idle cycles toggle it.
module bvs_flash import bvs_pkg::*; (
    input logic CLK, FLASH_RD,
    input logic [15:0] FLASH_ADDR,
    input logic [7:0] sig,
    output logic [7:0] FLASH_RDATA);
    timeunit 1ns / 1ps;
    // Inverted when idle so a stale byte never passes for a fresh one
    always_ff @(posedge CLK) FLASH_RDATA <= FLASH_RD && FLASH_ADDR == BVS_SIG_ADDR
        ? sig : ~FLASH_RDATA;
endmodule

//--- tb_top.sv
// Bench: boots over a signature table, then leaves the loader; flash model drives read data.
module tb_top import bvs_pkg::*; ;
    timeunit 1ns / 1ps;
    logic CLK = 0, RST_N = 0, LOADER_EXIT = 0, LOADER_TWO_WIRE = 0, FLASH_RD, CORE_RUN, LOADER_MODE;
    logic [15:0] FLASH_ADDR, START_VEC;
    logic [7:0] FLASH_RDATA, P0_ROUTE_MASK, sig;
    logic [25:0] seen;
    int errors = 0, n_checks = 0;
    // Row: signature, strap, vector, mode, pin mask; loader row last for the exit case
    logic [33:0] rows [3] = '{34'h3FE000000, 34'h297F4010C, 34'h295F40130};
    assign seen = {CORE_RUN, START_VEC, LOADER_MODE, P0_ROUTE_MASK};
    bvs_boot_vector_select u_bvs_boot_vector_select (.*);
    bvs_flash u_bvs_flash (.*);
    initial forever #4 CLK = ~CLK;
    task automatic chk(logic [25:0] got, exp);
        n_checks++;
        errors += got !== exp;
        if (got !== exp) $display("wrong value %0t %h %h", $time, got, exp);
    endtask
    task automatic wrap_up;
        $display("%0d checks, %0d errors", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        foreach (rows[r]) begin
            @(posedge CLK);
            {sig, LOADER_TWO_WIRE, RST_N} <= {rows[r][33:25], 1'b0};
            repeat (6) @(posedge CLK);
            RST_N <= 1;
            repeat (3) @(negedge CLK);
            chk(seen, {1'b1, rows[r][24:0]});
        end
        @(posedge CLK);
        {sig, LOADER_EXIT} <= 9'h001;
        @(posedge CLK);
        LOADER_EXIT <= 0;
        @(negedge CLK);
        chk(seen, {1'b1, BVS_LOADER_VEC, 9'h000});
        // Mid-run reset with exit already raised: the sample must win over the exit
        @(posedge CLK);
        {sig, LOADER_EXIT, RST_N} <= {BVS_SIG_PRESENT, 2'b10};
        @(negedge CLK);
        chk(seen, 26'h0);
        chk({25'h0, FLASH_RD}, 26'h1);
        chk({10'h0, FLASH_ADDR}, {10'h0, BVS_SIG_ADDR});
        repeat (5) @(posedge CLK);
        RST_N <= 1;
        repeat (2) @(negedge CLK);
        chk({25'h0, FLASH_RD}, 26'h0);
        @(negedge CLK);
        chk(seen, {1'b1, BVS_LOADER_VEC, 9'h130});
        @(negedge CLK);
        chk(seen, {1'b1, BVS_LOADER_VEC, 9'h000});
        wrap_up;
    end
endmodule
